/* rtl/adc_conversion_sequencer.sv */
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ns
// How it works
// - A conversion takes exactly 15 converter clocks, sampling through result load.
// - Writing busy high starts a conversion and powers the converter up at once.
// - Sample turns on at the first converter edge after the write, for three clocks.
// - Cycles split as 3 sample, 1 auto-zero, 10 bit decisions, 1 load.
// - Completion clears the busy flag and powers the converter down.
// - All ten result bits load into both result registers in one edge.
// - While busy, writes to control bits other than busy are ignored.
// - Software may clear busy to stop; one write then reloads fields and restarts.
// - Converter clock is main clock over a prescaler with two settings.
// - With busy low the converter clock is gated and power stays off.
// - Stop or sleep powers down; the conversion restarts on wake with invalid result.
// - A debug breakpoint does not interrupt a running conversion.
// - Offset null config enables the amplifier in open-loop mode.
// - Any reset discards both stored offset codes.
// - Each offset register holds a seven-bit sign-magnitude code.
// - A calibration reference enable connects its reference and cuts the input mux.
// - Reset loads both offset registers with 040h.
module adc_conversion_sequencer #(
  parameter int unsigned DIV_A = adc_seq_pkg::PRESCALE_DIV_A,
  parameter int unsigned DIV_B = adc_seq_pkg::PRESCALE_DIV_B
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        low_power_mode,
  input  wire logic        comparator_high,
  output logic             conv_power_on,
  output logic             conv_clock_run,
  output logic             sample_on,
  output logic             autozero_on,
  output logic      [9:0]  sar_trial,
  output logic      [2:0]  channel_select,
  output logic             conv_mode,
  output logic      [2:0]  amp_gain,
  output logic             amp_enable,
  output logic             amp_open_loop,
  output logic             temp_sensor_enable,
  output logic             aux_amp_enable,
  output logic             n_cal_reference,
  output logic             p_cal_reference,
  output logic             input_mux_enable,
  output logic      [6:0]  nchan_offset_code,
  output logic      [6:0]  pchan_offset_code
);

  localparam logic [3:0] SAMPLE_LAST  = 4'(adc_seq_pkg::SAMPLE_CYCLES - 1);
  localparam logic [3:0] CONVERT_LAST = 4'(adc_seq_pkg::CONVERT_CYCLES - 1);

  adc_seq_pkg::seq_state_t state;
  adc_seq_pkg::seq_state_t next_state;

  logic [7:0] conv_control_reg;
  logic [7:0] gain_control_reg;
  logic [7:0] nchan_offset_reg;
  logic [7:0] pchan_offset_reg;
  logic [9:0] result_pair;
  logic [9:0] sar;
  logic [3:0] step;
  logic       result_invalid;
  logic       tick;

  logic [7:0] next_conv_control_reg;
  logic [7:0] next_gain_control_reg;
  logic [7:0] next_nchan_offset_reg;
  logic [7:0] next_pchan_offset_reg;
  logic [9:0] next_result_pair;
  logic [9:0] next_sar;
  logic [3:0] next_step;
  logic       next_result_invalid;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  logic setup;
  logic wr;
  logic busy;
  logic sw_start;
  logic sw_stop;

  assign setup = psel && !penable;
  assign wr    = psel && penable && pwrite && pready;
  assign busy  = conv_control_reg[adc_seq_pkg::BUSY_BIT];

  // Converter clock only runs while busy, and not while the core sleeps
  conv_prescaler #(
    .DIV_A (DIV_A),
    .DIV_B (DIV_B)
  ) u_prescaler (
    .clk      (clk),
    .reset    (reset),
    .enable   (busy && !low_power_mode),
    .select_b (conv_control_reg[adc_seq_pkg::PRESCALE_BIT]),
    .tick     (tick)
  );

  // APB slave: zero wait states, answer prepared in the setup cycle
  always_comb begin
    next_prdata  = '0;
    next_pready  = setup;
    next_pslverr = 1'b0;
    if (setup) begin
      if (paddr == adc_seq_pkg::CONV_CONTROL_OFFSET) begin
        next_prdata[7:0] = conv_control_reg;
      end else if (paddr == adc_seq_pkg::RESULT_HIGH_OFFSET) begin
        next_prdata[7:0] = result_pair[9:2];
      end else if (paddr == adc_seq_pkg::RESULT_LOW_OFFSET) begin
        next_prdata[7:0] = {result_pair[1:0], 6'h00};
      end else if (paddr == adc_seq_pkg::GAIN_CONTROL_OFFSET) begin
        next_prdata[7:0] = gain_control_reg;
      end else if (paddr == adc_seq_pkg::NCHAN_OFFSET_OFFSET) begin
        next_prdata[7:0] = nchan_offset_reg;
      end else if (paddr == adc_seq_pkg::PCHAN_OFFSET_OFFSET) begin
        next_prdata[7:0] = pchan_offset_reg;
      end else if (paddr == adc_seq_pkg::CONV_STATUS_OFFSET) begin
        next_prdata[adc_seq_pkg::STATUS_INVALID_BIT] = result_invalid;
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign sw_start = wr && (paddr == adc_seq_pkg::CONV_CONTROL_OFFSET)
                    && pwdata[adc_seq_pkg::BUSY_BIT] && !busy;
  assign sw_stop  = wr && (paddr == adc_seq_pkg::CONV_CONTROL_OFFSET)
                    && !pwdata[adc_seq_pkg::BUSY_BIT] && busy;

  // Register file and conversion sequence share one next-state block
  always_comb begin
    next_conv_control_reg = conv_control_reg;
    next_gain_control_reg = gain_control_reg;
    next_nchan_offset_reg = nchan_offset_reg;
    next_pchan_offset_reg = pchan_offset_reg;
    next_result_pair      = result_pair;
    next_result_invalid   = result_invalid;
    next_state            = state;
    next_sar              = sar;
    next_step             = step;

    if (wr && paddr == adc_seq_pkg::CONV_CONTROL_OFFSET) begin
      if (busy) begin
        // Only the busy bit is writable mid-conversion
        next_conv_control_reg[adc_seq_pkg::BUSY_BIT] = pwdata[adc_seq_pkg::BUSY_BIT];
      end else begin
        next_conv_control_reg = pwdata[7:0];
      end
    end else if (wr && paddr == adc_seq_pkg::GAIN_CONTROL_OFFSET) begin
      next_gain_control_reg = pwdata[7:0];
    end else if (wr && paddr == adc_seq_pkg::NCHAN_OFFSET_OFFSET) begin
      next_nchan_offset_reg = pwdata[7:0];
    end else if (wr && paddr == adc_seq_pkg::PCHAN_OFFSET_OFFSET) begin
      next_pchan_offset_reg = pwdata[7:0];
    end

    if (sw_start) begin
      next_state          = adc_seq_pkg::SEQ_ARMED;
      next_result_invalid = 1'b0;
    end else if (sw_stop) begin
      next_state = adc_seq_pkg::SEQ_IDLE;
    end else if (busy && low_power_mode) begin
      // Sampled charge is lost; rerun from the start, result flagged bad
      if (state != adc_seq_pkg::SEQ_ARMED) begin
        next_result_invalid = 1'b1;
      end
      next_state = adc_seq_pkg::SEQ_ARMED;
    end else if (tick) begin
      // No debug-halt term: a breakpoint lets the conversion finish
      case (state)
        adc_seq_pkg::SEQ_ARMED: begin
          next_state = adc_seq_pkg::SEQ_SAMPLE;
          next_step  = '0;
        end
        adc_seq_pkg::SEQ_SAMPLE: begin
          if (step == SAMPLE_LAST) begin
            next_state = adc_seq_pkg::SEQ_AUTOZERO;
          end else begin
            next_step = step + 4'h1;
          end
        end
        adc_seq_pkg::SEQ_AUTOZERO: begin
          next_state = adc_seq_pkg::SEQ_CONVERT;
          next_step  = '0;
          next_sar   = 10'h200;
        end
        adc_seq_pkg::SEQ_CONVERT: begin
          // Trial bit is 9 - step; the comparator decides whether it stays
          if (!comparator_high) begin
            next_sar[4'd9 - step] = 1'b0;
          end
          if (step == CONVERT_LAST) begin
            next_state = adc_seq_pkg::SEQ_LOAD;
          end else begin
            next_sar[4'd8 - step] = 1'b1;
            next_step             = step + 4'h1;
          end
        end
        adc_seq_pkg::SEQ_LOAD: begin
          next_result_pair = sar;
          next_state       = adc_seq_pkg::SEQ_IDLE;
          next_conv_control_reg[adc_seq_pkg::BUSY_BIT] = 1'b0;
        end
        default: begin
          next_state = adc_seq_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Offset codes live only in flops: every reset restores 040h
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_control_reg <= adc_seq_pkg::CONV_CONTROL_RESET;
      gain_control_reg <= adc_seq_pkg::GAIN_CONTROL_RESET;
      nchan_offset_reg <= adc_seq_pkg::OFFSET_RESET;
      pchan_offset_reg <= adc_seq_pkg::OFFSET_RESET;
      result_pair      <= adc_seq_pkg::RESULT_RESET;
      result_invalid   <= 1'b0;
      state            <= adc_seq_pkg::SEQ_IDLE;
      sar              <= '0;
      step             <= '0;
    end else begin
      conv_control_reg <= next_conv_control_reg;
      gain_control_reg <= next_gain_control_reg;
      nchan_offset_reg <= next_nchan_offset_reg;
      pchan_offset_reg <= next_pchan_offset_reg;
      result_pair      <= next_result_pair;
      result_invalid   <= next_result_invalid;
      state            <= next_state;
      sar              <= next_sar;
      step             <= next_step;
    end
  end

  // Analog-facing controls, all registered from the next values
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_power_on      <= 1'b0;
      conv_clock_run     <= 1'b0;
      sample_on          <= 1'b0;
      autozero_on        <= 1'b0;
      sar_trial          <= '0;
      channel_select     <= '0;
      conv_mode          <= 1'b0;
      amp_gain           <= '0;
      amp_enable         <= 1'b0;
      amp_open_loop      <= 1'b0;
      temp_sensor_enable <= 1'b0;
      aux_amp_enable     <= 1'b0;
      n_cal_reference    <= 1'b0;
      p_cal_reference    <= 1'b0;
      input_mux_enable   <= 1'b1;
      nchan_offset_code  <= adc_seq_pkg::OFFSET_RESET[6:0];
      pchan_offset_code  <= adc_seq_pkg::OFFSET_RESET[6:0];
    end else begin
      conv_power_on  <= next_conv_control_reg[adc_seq_pkg::BUSY_BIT]
                        && !low_power_mode;
      conv_clock_run <= next_conv_control_reg[adc_seq_pkg::BUSY_BIT]
                        && !low_power_mode;
      sample_on      <= next_state == adc_seq_pkg::SEQ_SAMPLE;
      autozero_on    <= next_state == adc_seq_pkg::SEQ_AUTOZERO;
      sar_trial      <= next_sar;
      channel_select <= next_conv_control_reg[adc_seq_pkg::CHANNEL_LSB +: adc_seq_pkg::CHANNEL_W];
      conv_mode      <= next_conv_control_reg[adc_seq_pkg::MODE_BIT];
      amp_gain       <= next_gain_control_reg[adc_seq_pkg::GAIN_LSB +: adc_seq_pkg::GAIN_W];
      amp_open_loop  <= next_gain_control_reg[adc_seq_pkg::NULL_CFG_BIT];
      amp_enable     <= next_gain_control_reg[adc_seq_pkg::NULL_CFG_BIT]
                        || (next_gain_control_reg[adc_seq_pkg::GAIN_LSB +: adc_seq_pkg::GAIN_W]
                            != 3'h0);
      temp_sensor_enable <= next_gain_control_reg[adc_seq_pkg::TEMP_EN_BIT];
      aux_amp_enable     <= next_gain_control_reg[adc_seq_pkg::AUX_AMP_BIT];
      n_cal_reference    <= next_nchan_offset_reg[adc_seq_pkg::CAL_EN_BIT];
      p_cal_reference    <= next_pchan_offset_reg[adc_seq_pkg::CAL_EN_BIT];
      input_mux_enable   <= !(next_nchan_offset_reg[adc_seq_pkg::CAL_EN_BIT]
                              || next_pchan_offset_reg[adc_seq_pkg::CAL_EN_BIT]);
      nchan_offset_code  <= next_nchan_offset_reg[6:0];
      pchan_offset_code  <= next_pchan_offset_reg[6:0];
    end
  end

endmodule : adc_conversion_sequencer

/* rtl/adc_seq_pkg.sv */
package adc_seq_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned RES_W  = 10;
  localparam int unsigned CODE_W = 7;

  // Register byte addresses
  localparam logic [7:0] CONV_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] RESULT_HIGH_OFFSET  = 8'h04;
  localparam logic [7:0] RESULT_LOW_OFFSET   = 8'h08;
  localparam logic [7:0] GAIN_CONTROL_OFFSET = 8'h0C;
  localparam logic [7:0] NCHAN_OFFSET_OFFSET = 8'h10;
  localparam logic [7:0] PCHAN_OFFSET_OFFSET = 8'h14;
  localparam logic [7:0] CONV_STATUS_OFFSET  = 8'h18;

  // conv_control_reg fields
  localparam int unsigned BUSY_BIT      = 0;
  localparam int unsigned PRESCALE_BIT  = 1;
  localparam int unsigned MODE_BIT      = 2;
  localparam int unsigned CHANNEL_LSB   = 3;
  localparam int unsigned CHANNEL_W     = 3;

  // gain_control_reg fields
  localparam int unsigned GAIN_LSB      = 0;
  localparam int unsigned GAIN_W        = 3;
  localparam int unsigned NULL_CFG_BIT  = 5;
  localparam int unsigned TEMP_EN_BIT   = 6;
  localparam int unsigned AUX_AMP_BIT   = 7;

  // Offset register fields
  localparam int unsigned CAL_EN_BIT    = 7;
  localparam int unsigned SIGN_BIT      = 6;

  // conv_status_reg fields
  localparam int unsigned STATUS_INVALID_BIT = 0;

  localparam logic [7:0] CONV_CONTROL_RESET = 8'h00;
  localparam logic [7:0] GAIN_CONTROL_RESET = 8'h00;
  localparam logic [7:0] OFFSET_RESET       = 8'h40;
  localparam logic [9:0] RESULT_RESET       = 10'h000;

  // Converter cycle split, 15 in total
  localparam int unsigned SAMPLE_CYCLES   = 3;
  localparam int unsigned AUTOZERO_CYCLES = 1;
  localparam int unsigned CONVERT_CYCLES  = 10;
  localparam int unsigned LOAD_CYCLES     = 1;
  localparam int unsigned TOTAL_CYCLES    =
    SAMPLE_CYCLES + AUTOZERO_CYCLES + CONVERT_CYCLES + LOAD_CYCLES;

  localparam int unsigned PRESCALE_DIV_A = 16;
  localparam int unsigned PRESCALE_DIV_B = 32;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_SAMPLE,
    SEQ_AUTOZERO,
    SEQ_CONVERT,
    SEQ_LOAD
  } seq_state_t;

endpackage : adc_seq_pkg

/* rtl/conv_prescaler.sv */
`timescale 1ns/1ns
module conv_prescaler #(
  parameter int unsigned DIV_A = adc_seq_pkg::PRESCALE_DIV_A,
  parameter int unsigned DIV_B = adc_seq_pkg::PRESCALE_DIV_B
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic enable,
  input  wire logic select_b,
  output logic      tick
);

  localparam int unsigned CNT_W = $clog2(DIV_B > DIV_A ? DIV_B : DIV_A);
  localparam logic [CNT_W-1:0] LAST_A = CNT_W'(DIV_A - 1);
  localparam logic [CNT_W-1:0] LAST_B = CNT_W'(DIV_B - 1);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_tick;

  // Counter held at zero while disabled, so no converter edge runs when idle
  always_comb begin
    next_count = '0;
    next_tick  = 1'b0;
    if (enable) begin
      if (count == (select_b ? LAST_B : LAST_A)) begin
        next_tick = 1'b1;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule : conv_prescaler

/* test/adc_seq_asserts.sv */
`timescale 1ns/1ns
module adc_seq_checker (
  input logic        clk,
  input logic        reset,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        low_power_mode,
  input logic        conv_power_on,
  input logic        conv_clock_run,
  input logic        sample_on,
  input logic        autozero_on,
  input logic        amp_enable,
  input logic        amp_open_loop,
  input logic        n_cal_reference,
  input logic        p_cal_reference,
  input logic        input_mux_enable,
  input logic [6:0]  nchan_offset_code,
  input logic [6:0]  pchan_offset_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_pready_access: assert property (psel && !penable |=> pready)
    else $error("no answer in access cycle");
  a_pready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_start_power: assert property (psel && penable && pready && pwrite && paddr == 8'h00
      && pwdata[0] && !low_power_mode |-> ##[1:2] conv_power_on)
    else $error("start write did not power converter");
  // Divide is unknown here; three periods of the least sensible divide of two give the floor
  a_sample_three: assert property ($rose(sample_on) |-> sample_on[*6])
    else $error("sample window too short");
  a_autozero_next: assert property ($fell(sample_on) && conv_power_on |-> ##[0:1] autozero_on)
    else $error("auto-zero missing after sample");
  a_gate_match: assert property (conv_clock_run == conv_power_on)
    else $error("clock gate and power disagree");
  a_low_power_off: assert property (low_power_mode |=> !conv_power_on)
    else $error("converter powered in low power");
  a_mux_cut: assert property (input_mux_enable == !(n_cal_reference || p_cal_reference))
    else $error("input mux not cut by reference");
  a_open_loop_amp: assert property (amp_open_loop |-> amp_enable)
    else $error("open loop without amplifier enable");
  a_offset_reset: assert property ($fell(reset) |-> nchan_offset_code == 7'h40
      && pchan_offset_code == 7'h40)
    else $error("offset codes not at reset value");

  c_sample: cover property ($rose(sample_on));
  c_low_power: cover property (low_power_mode && conv_power_on);
  c_cal_ref: cover property (n_cal_reference && amp_open_loop);
endmodule : adc_seq_checker

/* test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  // Package divides give 1.5625 MHz and 781 kHz, inside the legal converter clock range
  localparam int DA = adc_seq_pkg::PRESCALE_DIV_A;
  localparam int DB = adc_seq_pkg::PRESCALE_DIV_B;
  // Amplifier settle wait of 1.05 ms at 40 ns per clock
  localparam int SETTLE = 26250;
  typedef struct {logic [7:0] ctrl; logic cmp; int len; logic [7:0] hi; logic [7:0] lo;} row_t;
  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic        pready, pslverr, errv, low_power_mode = 1'b0, comparator_high = 1'b0;
  logic        conv_power_on, conv_clock_run, sample_on, autozero_on, conv_mode;
  logic [9:0]  sar_trial;
  logic [2:0]  channel_select, amp_gain;
  logic        amp_enable, amp_open_loop, temp_sensor_enable, aux_amp_enable;
  logic        n_cal_reference, p_cal_reference, input_mux_enable;
  logic [6:0]  nchan_offset_code, pchan_offset_code;
  int          bad_count = 0, n_tests = 0, len;
  row_t        rows [3] = '{'{8'h0D, 1'b1, 15*DA, 8'hFF, 8'hC0},
                            '{8'h3B, 1'b0, 15*DB, 8'h00, 8'h00},
                            '{8'h13, 1'b1, 15*DB, 8'hFF, 8'hC0}};

  always #20 clk = ~clk;

  adc_conversion_sequencer #(.DIV_A(DA), .DIV_B(DB)) i_adc_conversion_sequencer (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .low_power_mode, .comparator_high, .conv_power_on, .conv_clock_run, .sample_on,
    .autozero_on, .sar_trial, .channel_select, .conv_mode, .amp_gain, .amp_enable,
    .amp_open_loop, .temp_sensor_enable, .aux_amp_enable, .n_cal_reference,
    .p_cal_reference, .input_mux_enable, .nchan_offset_code, .pchan_offset_code);

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Idle edge first, so a release and a new setup never share a time step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No limit here: only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Extra edge lets the registered outputs settle before they are checked
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    @(posedge clk);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, {24'h0, exp});
  endtask : rdchk

  task automatic conv_len;
    len = 0;
    while (sample_on !== 1'b1) begin
      @(posedge clk);
    end
    while (conv_power_on === 1'b1) begin
      @(posedge clk);
      len++;
    end
  endtask : conv_len

  initial begin
    // Three settle waits plus about three thousand clocks of conversions and bus traffic
    repeat (90000) @(posedge clk);
    bad_count++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rdchk(8'h00, 8'h00);
    rdchk(8'h0C, 8'h00);
    rdchk(8'h10, 8'h40);
    rdchk(8'h14, 8'h40);
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(errv), 32'h1);
    $display("test reset and map done");
    foreach (rows[i]) begin
      comparator_high <= rows[i].cmp;
      wr(8'h00, rows[i].ctrl);
      chk(32'(channel_select), 32'(rows[i].ctrl[5:3]));
      chk(32'(conv_mode), 32'(rows[i].ctrl[2]));
      conv_len();
      chk(len, rows[i].len);
      chk(32'(sar_trial), 32'({rows[i].hi, rows[i].lo[7:6]}));
      rdchk(8'h00, rows[i].ctrl & 8'h3E);
      rdchk(8'h04, rows[i].hi);
      rdchk(8'h08, rows[i].lo);
    end
    $display("test conversion rows done");
    wr(8'h00, 8'h0B);
    repeat (60) @(posedge clk);
    wr(8'h00, 8'h3F);
    chk(32'(channel_select), 32'h1);
    rdchk(8'h00, 8'h0B);
    wr(8'h00, 8'h00);
    repeat (2) @(posedge clk);
    chk(32'(conv_power_on), 32'h0);
    wr(8'h00, 8'h25);
    chk(32'(channel_select), 32'h4);
    conv_len();
    chk(len, 15*DA);
    $display("test busy lock and stop done");
    wr(8'h00, 8'h01);
    repeat (100) @(posedge clk);
    low_power_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(conv_power_on), 32'h0);
    low_power_mode <= 1'b0;
    conv_len();
    chk(len, 15*DA);
    rdchk(8'h18, 8'h01);
    wr(8'h00, 8'h01);
    rdchk(8'h18, 8'h00);
    conv_len();
    $display("test low power done");
    // Offset nulling as software runs it; two codes on the N pair and one on the P pair are enough here
    comparator_high <= 1'b1;
    wr(8'h0C, 8'h20);
    wr(8'h10, 8'hC0);
    repeat (SETTLE) @(posedge clk);
    wr(8'h00, 8'h01);
    conv_len();
    rdchk(8'h04, 8'hFF);
    comparator_high <= 1'b0;
    wr(8'h10, 8'hE0);
    repeat (SETTLE) @(posedge clk);
    wr(8'h00, 8'h01);
    conv_len();
    rdchk(8'h04, 8'h00);
    wr(8'h10, 8'hC0);
    wr(8'h10, 8'h40);
    chk(32'({n_cal_reference, nchan_offset_code}), 32'h40);
    wr(8'h14, 8'hC0);
    chk(32'({p_cal_reference, input_mux_enable}), 32'h2);
    repeat (SETTLE) @(posedge clk);
    wr(8'h00, 8'h01);
    conv_len();
    rdchk(8'h04, 8'h00);
    wr(8'h14, 8'h80);
    wr(8'h14, 8'h00);
    wr(8'h0C, 8'h00);
    chk(32'({amp_open_loop, input_mux_enable, pchan_offset_code}), 32'h080);
    $display("test offset nulling done");
    wr(8'h0C, 8'h25);
    chk(32'(amp_gain), 32'h5);
    chk(32'({amp_enable, amp_open_loop}), 32'h3);
    wr(8'h10, 8'hC0);
    chk(32'({n_cal_reference, input_mux_enable}), 32'h2);
    chk(32'(nchan_offset_code), 32'h40);
    wr(8'h14, 8'hFF);
    chk(32'({p_cal_reference, pchan_offset_code}), 32'hFF);
    wr(8'h14, 8'h3F);
    wr(8'h10, 8'h00);
    chk(32'(input_mux_enable), 32'h1);
    wr(8'h0C, 8'hC0);
    chk(32'({temp_sensor_enable, aux_amp_enable, amp_open_loop}), 32'h6);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rdchk(8'h10, 8'h40);
    rdchk(8'h14, 8'h40);
    rdchk(8'h0C, 8'h00);
    $display("test amplifier and offset done");
    test_done();
  end
endmodule : tb_top

bind adc_conversion_sequencer adc_seq_checker i_adc_seq_checker (
  .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .low_power_mode,
  .conv_power_on, .conv_clock_run, .sample_on, .autozero_on, .amp_enable, .amp_open_loop,
  .n_cal_reference, .p_cal_reference, .input_mux_enable, .nchan_offset_code,
  .pchan_offset_code);
